// [design/pgs_pkg.sv]
// package for the power-good source select and fault latch block
// assumes a 40 MHz apb clock and one register word per aligned 32-bit address
package pgs_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] PGS_IDX_CTRL = 8'h17;
  localparam logic [7:0] PGS_IDX_SEL_A = 8'h18;
  localparam logic [7:0] PGS_IDX_FAULT_A = 8'h19;
  localparam logic [7:0] PGS_IDX_SEL_B = 8'h1A;
  localparam logic [7:0] PGS_IDX_STATUS = 8'h20;

  // select register fields (same layout for both outputs)
  localparam int PGS_SEL_RISE_DELAY_BIT = 7;
  localparam int PGS_SEL_THERMAL_BIT = 6;
  localparam int PGS_SEL_ANALOG_BIT = 5;
  localparam int PGS_SEL_MON_B_BIT = 4;
  localparam int PGS_SEL_MON_A_BIT = 3;
  localparam int PGS_SEL_STEP_UP_BIT = 2;
  localparam int PGS_SEL_STEP_DOWN_B_BIT = 1;
  localparam int PGS_SEL_STEP_DOWN_A_BIT = 0;
  localparam int PGS_NUM_SOURCES = 7;

  // control register fields
  localparam int PGS_CTRL_A_POLARITY_BIT = 0;
  localparam int PGS_CTRL_A_GATING_BIT = 2;
  localparam int PGS_CTRL_B_POLARITY_BIT = 4;
  localparam logic [7:0] PGS_CTRL_MASK = 8'h15;

  // status register fields
  localparam int PGS_STAT_OUT_A_BIT = 8;
  localparam int PGS_STAT_OUT_B_BIT = 9;

  // reset values before the configuration memory is loaded
  localparam logic [7:0] PGS_SEL_RESET = 8'h00;
  localparam logic [7:0] PGS_FAULT_RESET = 8'h00;
  localparam logic [7:0] PGS_CTRL_RESET = 8'h00;

  // timing
  localparam longint PGS_CLK_PERIOD_PS = 25000;
  localparam longint PGS_RISE_DELAY_MS = 11;
  localparam int PGS_RISE_DELAY_CYC =
    int'((PGS_RISE_DELAY_MS * 64'd1000000000 + PGS_CLK_PERIOD_PS - 1) / PGS_CLK_PERIOD_PS);

  // validity of each monitored source, one means valid
  typedef struct packed {
    logic thermal_ok;
    logic analog_supply_ok;
    logic monitor_b_ok;
    logic monitor_a_ok;
    logic step_up_ok;
    logic step_down_b_ok;
    logic step_down_a_ok;
  } pgs_src_s;

  // defaults held in one-time configuration memory
  typedef struct packed {
    logic [7:0] sel_a;
    logic [7:0] sel_b;
    logic [7:0] ctrl;
  } pgs_otp_s;

  typedef enum logic [1:0] {
    PGS_IDLE = 2'b00,
    PGS_WAIT = 2'b01,
    PGS_GOOD = 2'b11
  } pgs_state_e;

endpackage

// [design/pgs_power_good.sv]
// power-good source select, rise delay and fault latch, apb slave
// assumes source validity inputs are synchronous to pclk and otp defaults are stable at reset release
//
// Added by the designer: the APB slave port.
module pgs_power_good
  import pgs_pkg::*;
#(
  parameter int RISE_DELAY_CYCLES = PGS_RISE_DELAY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pgs_src_s src_valid,
  input wire pgs_otp_s otp_defaults,
  output logic power_good_out_a,
  output logic power_good_out_b
);

  localparam int CNT_W = $clog2(RISE_DELAY_CYCLES + 1);

  logic otp_loaded;
  logic [7:0] sel_a;
  logic [7:0] sel_b;
  logic [7:0] ctrl;
  logic [7:0] fault_a;
  // per-source fault latches of output a
  logic out_a_thermal_fault;
  logic out_a_analog_supply_fault;
  logic out_a_monitor_b_fault;
  logic out_a_monitor_a_fault;
  logic out_a_step_up_fault;
  logic out_a_step_down_b_fault;
  logic out_a_step_down_a_fault;
  logic [6:0] fault_clr;
  logic fault_wr;
  logic [6:0] bad_a;
  logic [6:0] bad_b;
  logic ok_a;
  logic ok_b;
  logic out_a_rise_delay_en;
  logic out_b_rise_delay_en;
  // rise-delay state and counter per output
  pgs_state_e st_a;
  pgs_state_e st_b;
  logic [CNT_W-1:0] cnt_a;
  logic [CNT_W-1:0] cnt_b;
  logic [31:0] next_prdata;
  logic addr_hit;
  logic access_start;
  logic access;
  logic wr;

  // sources that are selected and currently invalid
  function automatic logic [6:0] failing(input logic [7:0] sel, input pgs_src_s v);
    failing = sel[PGS_NUM_SOURCES-1:0] & ~v;
  endfunction

  function automatic logic word_at(input logic [11:0] a, input logic [7:0] idx);
    word_at = (a == {2'b00, idx, 2'b00});
  endfunction

  // set wins over clear, so an event in the clearing cycle is never lost
  function automatic logic fault_next(input logic cur, input logic set, input logic clr);
    fault_next = set | (cur & ~clr);
  endfunction

  // the counter stops at the last cycle of the delay
  function automatic logic delay_done(input logic [CNT_W-1:0] c);
    delay_done = (c >= CNT_W'(RISE_DELAY_CYCLES - 1));
  endfunction

  // apb handshake: pready comes one cycle into the access phase
  assign access = clk_en && psel && penable && pready;
  assign wr = access && pwrite && !pslverr && pstrb[0];
  // a transfer is taken on the first access cycle
  assign access_start = clk_en && psel && penable && !pready;

  always_comb begin
    addr_hit = word_at(paddr, PGS_IDX_CTRL) || word_at(paddr, PGS_IDX_SEL_A) ||
               word_at(paddr, PGS_IDX_FAULT_A) || word_at(paddr, PGS_IDX_SEL_B) ||
               word_at(paddr, PGS_IDX_STATUS);
    next_prdata = 32'h0000_0000;
    if (word_at(paddr, PGS_IDX_CTRL)) begin
      next_prdata[7:0] = ctrl;
    end else if (word_at(paddr, PGS_IDX_SEL_A)) begin
      next_prdata[7:0] = sel_a;
    end else if (word_at(paddr, PGS_IDX_FAULT_A)) begin
      next_prdata[7:0] = fault_a;
    end else if (word_at(paddr, PGS_IDX_SEL_B)) begin
      next_prdata[7:0] = sel_b;
    end else if (word_at(paddr, PGS_IDX_STATUS)) begin
      next_prdata[PGS_NUM_SOURCES-1:0] = src_valid;
      next_prdata[PGS_STAT_OUT_A_BIT] = power_good_out_a;
      next_prdata[PGS_STAT_OUT_B_BIT] = power_good_out_b;
    end
  end

  // exactly one wait state: pready rises on the second access cycle and lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && penable && !pready;
    end
  end

  // an unmapped word answers with an error and has no side effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= psel && penable && !pready && !addr_hit;
    end
  end

  // read data only moves when a transfer is taken, so it stands with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access_start) begin
      prdata <= (pwrite || !addr_hit) ? 32'h0000_0000 : next_prdata;
    end
  end

  // defaults are taken one cycle after reset release, since an async reset may only load constants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_loaded <= 1'b0;
    end else if (clk_en) begin
      otp_loaded <= 1'b1;
    end
  end

  // select a: loaded once from configuration memory, then owned by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_a <= PGS_SEL_RESET;
    end else if (clk_en) begin
      if (!otp_loaded) begin
        sel_a <= otp_defaults.sel_a;
      end else if (wr && word_at(paddr, PGS_IDX_SEL_A)) begin
        sel_a <= pwdata[7:0];
      end
    end
  end

  // select b mirrors select a for output b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_b <= PGS_SEL_RESET;
    end else if (clk_en) begin
      if (!otp_loaded) begin
        sel_b <= otp_defaults.sel_b;
      end else if (wr && word_at(paddr, PGS_IDX_SEL_B)) begin
        sel_b <= pwdata[7:0];
      end
    end
  end

  // control: reserved bits always read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= PGS_CTRL_RESET;
    end else if (clk_en) begin
      if (!otp_loaded) begin
        ctrl <= otp_defaults.ctrl & PGS_CTRL_MASK;
      end else if (wr && word_at(paddr, PGS_IDX_CTRL)) begin
        ctrl <= pwdata[7:0] & PGS_CTRL_MASK;
      end
    end
  end

  // masked sources never count as failing
  // an empty select means nothing can fail, so the output stays good, except output a while gating holds a fault latched earlier
  assign bad_a = failing(sel_a, src_valid);
  assign bad_b = failing(sel_b, src_valid);

  // a write of one clears a bit only while its source is valid; set wins in the same cycle
  assign fault_wr = wr && word_at(paddr, PGS_IDX_FAULT_A);
  assign fault_clr = {7{fault_wr}} & pwdata[6:0] & src_valid;
  assign fault_a = {1'b0, out_a_thermal_fault, out_a_analog_supply_fault, out_a_monitor_b_fault,
                    out_a_monitor_a_fault, out_a_step_up_fault, out_a_step_down_b_fault, out_a_step_down_a_fault};

  // thermal warning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_thermal_fault <= PGS_FAULT_RESET[PGS_SEL_THERMAL_BIT];
    end else if (clk_en) begin
      out_a_thermal_fault <= fault_next(out_a_thermal_fault, bad_a[6], fault_clr[6]);
    end
  end

  // analog supply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_analog_supply_fault <= PGS_FAULT_RESET[PGS_SEL_ANALOG_BIT];
    end else if (clk_en) begin
      out_a_analog_supply_fault <= fault_next(out_a_analog_supply_fault, bad_a[5], fault_clr[5]);
    end
  end

  // external monitor b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_monitor_b_fault <= PGS_FAULT_RESET[PGS_SEL_MON_B_BIT];
    end else if (clk_en) begin
      out_a_monitor_b_fault <= fault_next(out_a_monitor_b_fault, bad_a[4], fault_clr[4]);
    end
  end

  // external monitor a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_monitor_a_fault <= PGS_FAULT_RESET[PGS_SEL_MON_A_BIT];
    end else if (clk_en) begin
      out_a_monitor_a_fault <= fault_next(out_a_monitor_a_fault, bad_a[3], fault_clr[3]);
    end
  end

  // step-up rail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_step_up_fault <= PGS_FAULT_RESET[PGS_SEL_STEP_UP_BIT];
    end else if (clk_en) begin
      out_a_step_up_fault <= fault_next(out_a_step_up_fault, bad_a[2], fault_clr[2]);
    end
  end

  // step-down rail b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_step_down_b_fault <= PGS_FAULT_RESET[PGS_SEL_STEP_DOWN_B_BIT];
    end else if (clk_en) begin
      out_a_step_down_b_fault <= fault_next(out_a_step_down_b_fault, bad_a[1], fault_clr[1]);
    end
  end

  // step-down rail a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_step_down_a_fault <= PGS_FAULT_RESET[PGS_SEL_STEP_DOWN_A_BIT];
    end else if (clk_en) begin
      out_a_step_down_a_fault <= fault_next(out_a_step_down_a_fault, bad_a[0], fault_clr[0]);
    end
  end

  // gating holds output a inactive until software clears every fault bit
  always_comb begin
    ok_a = ctrl[PGS_CTRL_A_GATING_BIT] ? ~|fault_a : ~|bad_a;
    out_a_rise_delay_en = sel_a[PGS_SEL_RISE_DELAY_BIT];
  end

  // output b has no latched gating, it always shows the live status
  always_comb begin
    ok_b = ~|bad_b;
    out_b_rise_delay_en = sel_b[PGS_SEL_RISE_DELAY_BIT];
  end

  // rise delay: falling is immediate, rising waits the full delay when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_a <= PGS_IDLE;
      cnt_a <= '0;
    end else if (clk_en) begin
      if (!ok_a) begin
        st_a <= PGS_IDLE;
        cnt_a <= '0;
      end else begin
        unique case (st_a)
          PGS_IDLE: begin
            cnt_a <= '0;
            st_a <= out_a_rise_delay_en ? PGS_WAIT : PGS_GOOD;
          end
          PGS_WAIT: begin
            if (delay_done(cnt_a)) begin
              st_a <= PGS_GOOD;
            end else begin
              cnt_a <= cnt_a + CNT_W'(1);
            end
          end
          PGS_GOOD: begin
            st_a <= PGS_GOOD;
          end
          default: begin
            st_a <= PGS_IDLE;
          end
        endcase
      end
    end
  end

  // a source that drops during the delay restarts the whole delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_b <= PGS_IDLE;
      cnt_b <= '0;
    end else if (clk_en) begin
      if (!ok_b) begin
        st_b <= PGS_IDLE;
        cnt_b <= '0;
      end else begin
        unique case (st_b)
          PGS_IDLE: begin
            cnt_b <= '0;
            st_b <= out_b_rise_delay_en ? PGS_WAIT : PGS_GOOD;
          end
          PGS_WAIT: begin
            if (delay_done(cnt_b)) begin
              st_b <= PGS_GOOD;
            end else begin
              cnt_b <= cnt_b + CNT_W'(1);
            end
          end
          PGS_GOOD: begin
            st_b <= PGS_GOOD;
          end
          default: begin
            st_b <= PGS_IDLE;
          end
        endcase
      end
    end
  end

  // output flops; reset shows the inactive level for polarity zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_good_out_a <= 1'b0;
    end else if (clk_en) begin
      power_good_out_a <= (st_a == PGS_GOOD) ^ ctrl[PGS_CTRL_A_POLARITY_BIT];
    end
  end

  // output b polarity sits in control bit 4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_good_out_b <= 1'b0;
    end else if (clk_en) begin
      power_good_out_b <= (st_b == PGS_GOOD) ^ ctrl[PGS_CTRL_B_POLARITY_BIT];
    end
  end

endmodule

// [testbench/pgs_power_good_properties.sv]
// checker for the power-good block: apb timing, decode and output steadiness
// bound to pgs_power_good, sees its ports only
module pgs_power_good_properties
  import pgs_pkg::*;
#(
  parameter int RISE_DELAY_CYCLES = PGS_RISE_DELAY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pgs_src_s src_valid,
  input wire logic power_good_out_a,
  input wire logic power_good_out_b
);
  logic [7:0] sel_seen;
  logic sel_known;
  int quiet;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // quiet counts enabled cycles with no source change and no bus traffic, and restarts from zero on any cycle with clk_en low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 0;
    end else if (!$stable(src_valid) || psel || !clk_en) begin
      quiet <= 0;
    end else if (quiet < 1000) begin
      quiet <= quiet + 1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_known <= 1'b0;
    end else if (clk_en && pready && pwrite && paddr == 12'h060 && pstrb[0]) begin
      sel_known <= 1'b1;
    end
  end
  always_ff @(posedge pclk) begin
    if (clk_en && pready && pwrite && paddr == 12'h060 && pstrb[0]) begin
      sel_seen <= pwdata[7:0];
    end
  end
  a_one_wait_state: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {12'h05C, 12'h060, 12'h064, 12'h068, 12'h080}))
    else $error("pslverr decode");
  a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read data");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:10] == 22'h0)
    else $error("upper read bits");
  a_fault_top_zero: assert property (pready && !pwrite && paddr == 12'h064 |-> prdata[31:7] == 25'h0)
    else $error("fault bit 7 set");
  a_sel_readback: assert property (pready && !pwrite && paddr == 12'h060 && sel_known |-> prdata[7:0] == sel_seen)
    else $error("select readback");
  a_out_steady: assert property (quiet > RISE_DELAY_CYCLES + 4 |-> $stable(power_good_out_a) && $stable(power_good_out_b))
    else $error("output moved while quiet");
  c_write: cover property (pready && pwrite);
  c_error: cover property (pready && pslverr);
  c_fall: cover property ($fell(power_good_out_a));
endmodule
bind pgs_power_good pgs_power_good_properties #(.RISE_DELAY_CYCLES(RISE_DELAY_CYCLES)) u_pgs_power_good_properties (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_valid(src_valid), .power_good_out_a(power_good_out_a), .power_good_out_b(power_good_out_b));

// [testbench/tb_top.sv]
// self-checking bench for pgs_power_good: apb master, source stimulus
// assumes a short rise delay parameter so the run stays brief
module tb_top
  import pgs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RISE = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr, out_a, out_b;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [6:0] src = 7'h7F;
  logic [23:0] otp = 0;
  logic clk_en = 1;
  logic [3:0] pstrb = 4'hF;
  int num_errors = 0, num_checks = 0;
  always #12.5 pclk = ~pclk;
  pgs_power_good #(.RISE_DELAY_CYCLES(RISE)) u_pgs_power_good (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_valid(pgs_src_s'(src)),
    .otp_defaults(pgs_otp_s'(otp)), .power_good_out_a(out_a), .power_good_out_b(out_b));
  task automatic stop_test;
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // every call starts and ends just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  initial begin
    #(25ns * 3000);
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hA66FA713));
    otp <= 24'($urandom);
    wt(6);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h060, 0, r); chk(r, {24'h0, otp[23:16]});
    apb(0, 12'h068, 0, r); chk(r, {24'h0, otp[15:8]});
    apb(0, 12'h05C, 0, r); chk(r, {24'h0, otp[7:0] & 8'h15});
    apb(1, 12'h05C, 0, r);
    apb(1, 12'h068, 0, r);
    for (int i = 0; i < 7; i++) begin
      apb(1, 12'h060, 8'(1 << i), r);
      src <= 7'($urandom) | 7'(1 << i);
      wt(4); chk(out_a, 1);
      src[i] <= 0; wt(4); chk(out_a, 0);
      apb(1, 12'h064, 8'(1 << i), r); apb(0, 12'h064, 0, r); chk(r, 1 << i);
      src[i] <= 1; wt(4); chk(out_a, 1);
      apb(1, 12'h064, 0, r); apb(0, 12'h064, 0, r); chk(r, 1 << i);
      apb(1, 12'h064, 8'(1 << i), r); apb(0, 12'h064, 0, r); chk(r, 0);
    end
    apb(1, 12'h060, 8'h81, r);
    src[0] <= 0; wt(4); src[0] <= 1; wt(4); chk(out_a, 0);
    wt(RISE + 2); chk(out_a, 1);
    apb(1, 12'h060, 8'h01, r);
    apb(1, 12'h064, 8'h01, r);
    apb(1, 12'h05C, 8'h04, r);
    src[0] <= 0; wt(4); src[0] <= 1; wt(4); chk(out_a, 0);
    apb(1, 12'h064, 8'h01, r); wt(4); chk(out_a, 1);
    apb(1, 12'h05C, 8'h01, r); wt(4); chk(out_a, 0);
    apb(1, 12'h068, 8'h82, r);
    src[1] <= 0; wt(4); chk(out_b, 0);
    src[1] <= 1; wt(4); chk(out_b, 0);
    clk_en <= 0; wt(RISE); clk_en <= 1; wt(2); chk(out_b, 0);
    wt(RISE + 2); chk(out_b, 1);
    apb(0, 12'h074, 0, r); chk(r, 0); chk(err, 1);
    pstrb <= 4'hE; apb(1, 12'h060, 8'h00, r); pstrb <= 4'hF;
    apb(0, 12'h060, 0, r); chk(r, 32'h0000_0001);
    apb(0, 12'h080, 0, r); chk(r, {22'h0, 2'b10, 1'b0, src});
    stop_test();
  end
endmodule
